// >>> core/ctrg_pkg.sv
// package: register map, field positions and constants of the trim register bank
package ctrg_pkg;
   localparam logic [7:0] ADDR_CELL6_TRIM     = 8'h16;
   localparam logic [7:0] ADDR_CELL_MSB_A     = 8'h17;
   localparam logic [7:0] ADDR_CELL_MSB_B     = 8'h18;
   localparam logic [7:0] ADDR_REFERENCE_MSB  = 8'h1b;
   localparam logic [7:0] ADDR_REFERENCE_LOW  = 8'h10;
   localparam int         OFFSET_LOW_POS      = 4;
   localparam int         GAIN_LOW_POS        = 0;
   localparam int         MSB_A_VALID_LSB     = 4;
   localparam int         CELL_TRIM_BITS      = 5;
   localparam int         REF_OFFSET_BITS     = 6;
   localparam int         REF_GAIN_BITS       = 5;
   localparam int         NUM_CELLS           = 6;
   localparam logic [7:0] TRIM_RESET          = 8'h00;
   localparam logic [5:0] BALANCE_RESET       = 6'h00;
   localparam int         OFFSET_STEP_UV      = 1000;
   localparam int         GAIN_STEP_PPM       = 1000;
   typedef enum logic [1:0] {
      CTRG_RUN      = 2'b00,
      CTRG_DRAIN    = 2'b01,
      CTRG_ARMED    = 2'b10
   } ctrg_power_t;
endpackage

// >>> core/ctrg_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
`default_nettype none
module ctrg_sync (
   // clock and control
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   // pin and filtered level
   input  wire logic pin,
   output logic      level
);
   logic s1;
   logic s2;
   logic s3;
   wire  agree = (s2 == s3);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
      end else if (clk_en) begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (agree) begin
            level <= s3;
         end
      end
   end
endmodule
`default_nettype wire

// >>> core/ctrg_regs.sv
// trim register bank with sleep/wake sequencing and balancing interlock
// Functional notes
// - 0x16 high nibble: cell6 offset low bits
// - 0x16 low nibble: cell6 gain low bits
// - 0x17 D7..D4: cell1, cell2 offset/gain tops
// - 0x18 D7..D0: cells 3-6 offset/gain tops
// - 0x1b D2..D0: reference offset bits, gain top
// - reference trims: 6-bit offset, 5-bit gain
// - sleep bit write enters shutdown
// - wake detector waits for regulator discharge
// - armed detector wakes on alert high
// - balancing only by host, never self-cycled
// - adjacent balancing requests keep both off
`timescale 1ns/10ps
`default_nettype none
module ctrg_regs #(
   parameter int CELLS = ctrg_pkg::NUM_CELLS
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // trim storage load (nonvolatile image)
   input  wire logic             trim_load,
   input  wire logic [7:0]       trim_load_addr,
   input  wire logic [7:0]       trim_load_data,
   // register read port
   input  wire logic             rd_en,
   input  wire logic [7:0]       rd_addr,
   output logic [7:0]            rd_data,
   output logic                  rd_hit,
   // power control
   input  wire logic             sleep_cmd,
   input  wire logic             regulator_output_zero,
   input  wire logic             alert_pin,
   output logic                  shutdown,
   output logic                  wake_armed,
   // balancing
   input  wire logic [CELLS-1:0] balance_req,
   output logic [CELLS-1:0]      balance_on,
   // assembled trims
   output logic [4:0]            cell6_offset_trim,
   output logic [4:0]            cell6_gain_trim,
   output logic [5:0]            ref_offset_trim,
   output logic [4:0]            ref_gain_trim
);
   logic [7:0]          cell6_trim;
   logic [7:0]          cell_trim_msb_a;
   logic [7:0]          cell_trim_msb_b;
   logic [7:0]          reference_trim_msb;
   // reference low trims: offset in the upper nibble, gain in the lower
   logic [7:0]          reference_low;
   logic [7:0]          rd_mux;
   ctrg_pkg::ctrg_power_t state;
   ctrg_pkg::ctrg_power_t next_state;
   logic                disch_s;
   logic                alert_s;

   ctrg_sync u_sync_disch (
      .clk     (clk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .pin     (regulator_output_zero),
      .level   (disch_s)
   );
   ctrg_sync u_sync_alert (
      .clk     (clk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .pin     (alert_pin),
      .level   (alert_s)
   );

   // stored images, unused bits forced to zero
   wire ld_c6   = trim_load && (trim_load_addr == ctrg_pkg::ADDR_CELL6_TRIM);
   wire ld_a    = trim_load && (trim_load_addr == ctrg_pkg::ADDR_CELL_MSB_A);
   wire ld_b    = trim_load && (trim_load_addr == ctrg_pkg::ADDR_CELL_MSB_B);
   wire ld_ref  = trim_load && (trim_load_addr == ctrg_pkg::ADDR_REFERENCE_MSB);
   // reference low trims have a load address of their own, not readable here
   wire ld_rlow = trim_load && (trim_load_addr == ctrg_pkg::ADDR_REFERENCE_LOW);
   wire [7:0] msb_a_in = {trim_load_data[7:4], 4'h0};
   wire [7:0] ref_in   = {5'h00, trim_load_data[2:0]};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cell6_trim         <= ctrg_pkg::TRIM_RESET;
         cell_trim_msb_a    <= ctrg_pkg::TRIM_RESET;
         cell_trim_msb_b    <= ctrg_pkg::TRIM_RESET;
         reference_trim_msb <= ctrg_pkg::TRIM_RESET;
         reference_low      <= ctrg_pkg::TRIM_RESET;
      end else if (clk_en) begin
         if (ld_c6) begin
            cell6_trim <= trim_load_data;
         end
         if (ld_a) begin
            cell_trim_msb_a <= msb_a_in;
         end
         if (ld_b) begin
            cell_trim_msb_b <= trim_load_data;
         end
         if (ld_ref) begin
            reference_trim_msb <= ref_in;
         end
         if (ld_rlow) begin
            reference_low <= trim_load_data;
         end
      end
   end

   // read decode
   wire hit_c6  = (rd_addr == ctrg_pkg::ADDR_CELL6_TRIM);
   wire hit_a   = (rd_addr == ctrg_pkg::ADDR_CELL_MSB_A);
   wire hit_b   = (rd_addr == ctrg_pkg::ADDR_CELL_MSB_B);
   wire hit_ref = (rd_addr == ctrg_pkg::ADDR_REFERENCE_MSB);
   always_comb begin
      if (hit_c6) begin
         rd_mux = cell6_trim;
      end else if (hit_a) begin
         rd_mux = cell_trim_msb_a;
      end else if (hit_b) begin
         rd_mux = cell_trim_msb_b;
      end else if (hit_ref) begin
         rd_mux = reference_trim_msb;
      end else begin
         rd_mux = 8'h00;
      end
   end
   wire rd_any = hit_c6 | hit_a | hit_b | hit_ref;

   // trim assembly: msb joined with low nibble
   wire [4:0] c6_off = {cell_trim_msb_b[1], cell6_trim[7:4]};
   wire [4:0] c6_gn  = {cell_trim_msb_b[0], cell6_trim[3:0]};
   wire [5:0] r_off  = {reference_trim_msb[2:1], reference_low[7:4]};
   wire [4:0] r_gn   = {reference_trim_msb[0], reference_low[3:0]};

   // power sequencing
   always_comb begin
      next_state = state;
      case (state)
         ctrg_pkg::CTRG_RUN: begin
            if (sleep_cmd) next_state = ctrg_pkg::CTRG_DRAIN;
         end
         ctrg_pkg::CTRG_DRAIN: begin
            if (disch_s) next_state = ctrg_pkg::CTRG_ARMED;
         end
         ctrg_pkg::CTRG_ARMED: begin
            if (alert_s) next_state = ctrg_pkg::CTRG_RUN;
         end
         default: next_state = ctrg_pkg::CTRG_RUN;
      endcase
   end

   // next-state decode
   wire going_run   = (next_state == ctrg_pkg::CTRG_RUN);
   wire going_armed = (next_state == ctrg_pkg::CTRG_ARMED);

   // interlock: a bit is blocked if either neighbour also requested
   // end switches have one neighbour only
   wire [CELLS-1:0] guard_free;
   for (genvar c = 0; c < CELLS; c++) begin : g_guard
      if (c == 0) begin : g_low_end
         assign guard_free[c] = !balance_req[c+1];
      end else if (c == CELLS - 1) begin : g_high_end
         assign guard_free[c] = !balance_req[c-1];
      end else begin : g_middle
         assign guard_free[c] = !balance_req[c-1] && !balance_req[c+1];
      end
   end
   // switches drop in the same cycle that shutdown rises
   wire [CELLS-1:0] next_balance = going_run ? (balance_req & guard_free) : '0;

   // power state and status outputs
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state      <= ctrg_pkg::CTRG_RUN;
         shutdown   <= 1'b0;
         wake_armed <= 1'b0;
      end else if (clk_en) begin
         state      <= next_state;
         shutdown   <= !going_run;
         wake_armed <= going_armed;
      end
   end

   // balancing switch drive
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         balance_on <= '0;
      end else if (clk_en) begin
         balance_on <= next_balance;
      end
   end

   // read answer, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_data <= 8'h00;
         rd_hit  <= 1'b0;
      end else if (clk_en) begin
         rd_data <= rd_en ? rd_mux : 8'h00;
         rd_hit  <= rd_en & rd_any;
      end
   end

   // assembled trim values
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cell6_offset_trim <= 5'h00;
         cell6_gain_trim   <= 5'h00;
         ref_offset_trim   <= 6'h00;
         ref_gain_trim     <= 5'h00;
      end else if (clk_en) begin
         cell6_offset_trim <= c6_off;
         cell6_gain_trim   <= c6_gn;
         ref_offset_trim   <= r_off;
         ref_gain_trim     <= r_gn;
      end
   end
endmodule
`default_nettype wire

// >>> test/ctrg_regs_monitor.sv
// checker: port assertions of the trim bank
`timescale 1ns/10ps
`default_nettype none
module ctrg_regs_monitor #(parameter int CELLS = 6) (
   // clock and read port
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_hit,
   // power and balancing
   input wire logic sleep_cmd,
   input wire logic regulator_output_zero,
   input wire logic alert_pin,
   input wire logic shutdown,
   input wire logic wake_armed,
   input wire logic [CELLS-1:0] balance_req,
   input wire logic [CELLS-1:0] balance_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic rd = clk_en && rd_en;
   msb_a_low_a: assert property (rd && rd_addr == 8'h17 |=> rd_hit && rd_data[3:0] == 4'h0)
      else $error("msb a low bits set");
   ref_msb_top_a: assert property (rd && rd_addr == 8'h1b |=> rd_hit && rd_data[7:3] == 5'h00)
      else $error("ref msb top bits set");
   sleep_enter_a: assert property (clk_en && sleep_cmd && !shutdown |=> shutdown)
      else $error("sleep ignored");
   drain_hold_a: assert property (shutdown && !wake_armed |=> shutdown)
      else $error("left shutdown unarmed");
   arm_cause_a: assert property ($rose(wake_armed) |-> $past(regulator_output_zero, 4))
      else $error("armed early");
   wake_exit_a: assert property (wake_armed && alert_pin |-> ##[1:6] !shutdown)
      else $error("no wake");
   no_pair_a: assert property ((balance_on & (balance_on >> 1)) == 0)
      else $error("adjacent on");
   host_only_a: assert property ($past(clk_en) |-> (balance_on & ~$past(balance_req)) == 0)
      else $error("self balancing");
   sleep_no_bal_a: assert property (shutdown |-> balance_on == '0)
      else $error("balancing in shutdown");
   c_sleep: cover property ($rose(shutdown));
   c_wake: cover property ($fell(shutdown));
   c_clash: cover property (&balance_req);
   c_freeze: cover property (!clk_en);
endmodule
bind ctrg_regs ctrg_regs_monitor #(.CELLS(CELLS)) i_mon (.clk, .reset_n, .clk_en, .rd_en, .rd_addr,
   .rd_data, .rd_hit, .sleep_cmd, .regulator_output_zero, .alert_pin, .shutdown, .wake_armed,
   .balance_req, .balance_on);
`default_nettype wire

// >>> test/ctrg_host.sv
// host model: balancing requests and sleep command
`timescale 1ns/10ps
`default_nettype none
module ctrg_host (
   // host intent
   input wire logic       measure,
   input wire logic [5:0] want,
   input wire logic       sleep_go,
   // device side
   output logic [5:0]     balance_req,
   output logic           sleep_cmd
);
   assign balance_req = measure ? 6'h00 : want;
   assign sleep_cmd = sleep_go;
endmodule
`default_nettype wire

// >>> test/test_cell_trim_regs_and_balance_guard.sv
// testbench: trim readback, balancing interlock, sleep and wake
`timescale 1ns/10ps
`default_nettype none
module test_cell_trim_regs_and_balance_guard;
   localparam logic [7:0] ADR [5] = '{8'h16, 8'h17, 8'h18, 8'h1b, 8'h10};
   localparam logic [7:0] MSK [5] = '{8'hff, 8'hf0, 8'hff, 8'h07, 8'h00};
   localparam logic [5:0] CB [4] = '{6'h03, 6'h3f, 6'h15, 6'h2a};
   logic clk = 0, reset_n = 0, ld = 0, rd_en = 0, zero = 0, alert = 0, meas = 0, sgo = 0;
   logic rhit, sd, armed, scmd;
   logic ce = 1;
   logic [7:0] la = 0, ldat = 0, ra = 0, lf = 8'h12, rdat, d [5];
   logic [5:0] want = 0, breq, bon, ro;
   logic [4:0] c6o, c6g, rg;
   int miscompares = 0, compares = 0, n;
   ctrg_host i_host (.measure(meas), .want, .sleep_go(sgo), .balance_req(breq), .sleep_cmd(scmd));
   ctrg_regs i_dut (.clk, .reset_n, .clk_en(ce), .trim_load(ld), .trim_load_addr(la),
      .trim_load_data(ldat), .rd_en, .rd_addr(ra), .rd_data(rdat), .rd_hit(rhit),
      .sleep_cmd(scmd), .regulator_output_zero(zero), .alert_pin(alert), .shutdown(sd),
      .wake_armed(armed), .balance_req(breq), .balance_on(bon), .cell6_offset_trim(c6o),
      .cell6_gain_trim(c6g), .ref_offset_trim(ro), .ref_gain_trim(rg));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [5:0] bal(input logic [5:0] r);
      return r & ~(r << 1) & ~(r >> 1);
   endfunction
   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, x);
      compares++;
      if (seen !== x) begin
         miscompares++;
         $display("unexpected at %0t: %h expected %h", $time, seen, x);
      end
   endtask
   task automatic await(ref logic s, input logic v);
      for (n = 0; n < 20 && s !== v; n++) @(negedge clk);
      if (s !== v) begin
         miscompares++;
         end_of_test;
      end
   endtask
   task automatic load(input logic [7:0] a, v);
      ld = 1;
      la = a;
      ldat = v;
      @(negedge clk);
   endtask
   // strobes stay up between back-to-back calls; the caller lowers them
   task automatic rd(input logic [7:0] a, x, input logic h);
      rd_en = 1;
      ra = a;
      @(negedge clk);
      chk(rdat, x);
      chk({7'h0, rhit}, {7'h0, h});
   endtask
   initial forever #4 clk = ~clk;
   initial begin
      repeat (20) @(negedge clk);
      reset_n = 1;
      for (int k = 0; k < 3; k++) begin
         foreach (d[i]) begin
            lf = lfsr(lf);
            d[i] = lf;
         end
         if (k == 0) d = '{8'h80, 8'hff, 8'h03, 8'hfe, 8'h8f};
         foreach (d[i]) load(ADR[i], d[i]);
         ld = 0;
         for (int i = 0; i < 4; i++) rd(ADR[i], d[i] & MSK[i], 1'b1);
         rd(8'h19, 8'h00, 1'b0);
         rd_en = 0;
         chk({3'h0, c6o}, {3'h0, d[2][1], d[0][7:4]});
         chk({3'h0, c6g}, {3'h0, d[2][0], d[0][3:0]});
         chk({2'h0, ro}, {2'h0, d[3][2:1], d[4][7:4]});
         chk({3'h0, rg}, {3'h0, d[3][0], d[4][3:0]});
      end
      for (int k = 0; k < 12; k++) begin
         lf = lfsr(lf);
         want = (k < 4) ? CB[k] : lf[5:0];
         repeat (2) @(negedge clk);
         chk({2'h0, bon}, {2'h0, bal(want)});
      end
      want = 6'h0c;
      repeat (2) @(negedge clk);
      chk({2'h0, bon}, 8'h00);
      // clock enable low must hold the switches while the request changes
      ce = 0;
      want = 6'h21;
      repeat (2) @(negedge clk);
      chk({2'h0, bon}, 8'h00);
      ce = 1;
      repeat (2) @(negedge clk);
      chk({2'h0, bon}, 8'h21);
      meas = 1;
      repeat (2) @(negedge clk);
      chk({2'h0, bon}, 8'h00);
      meas = 0;
      sgo = 1;
      @(negedge clk) sgo = 0;
      alert = 1;
      repeat (10) @(negedge clk);
      chk({6'h0, sd, armed}, 8'h02);
      chk({2'h0, bon}, 8'h00);
      zero = 1;
      await(armed, 1'b1);
      await(sd, 1'b0);
      end_of_test;
   end
endmodule
`default_nettype wire
